// [dv/bgr_dp_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Execution stage stand-in: write-back and status word.
// *****
module bgr_dp_model import bgr_pkg::*; (
   // Clock.
   input wire logic core_clk,
   // Write-back and status towards the register file.
   output var bgr_wr_req_t wr_req,
   output var logic instruction_end_signal,
   output var logic psw_bank_nxt,
   output var logic [3:0] psw_dsr_nxt
);
   // Quiet at time zero: no write and no end pulse.
   initial begin
      wr_req = '0;
      instruction_end_signal = 1'b0;
      psw_bank_nxt = 1'b0;
      psw_dsr_nxt = 4'h0;
   end
   // One end cycle; a write only counts when it rides on the pulse.
   task automatic commit(input logic e, w, f, d, s, input logic [2:0] n, input logic [63:0] v,
      input logic b, input logic [3:0] q);
      @(posedge core_clk);
      wr_req <= '{w, f, d, s, n, v};
      instruction_end_signal <= e;
      psw_bank_nxt <= b;
      psw_dsr_nxt <= q;
      @(posedge core_clk);
      // Released fields carry inverted leftovers, so stale data never looks valid.
      wr_req <= '{1'b0, ~f, ~d, ~s, ~n, ~v};
      instruction_end_signal <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [dv/bgr_regfile_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Port checks for the banked register file.
// *****
module bgr_regfile_asserts import bgr_pkg::*; (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Sequencer and operand path.
   input wire logic instruction_end_signal,
   input wire logic psw_bank_nxt,
   input wire bgr_rd_req_t rd_req,
   input wire logic [63:0] opa_data,
   input wire logic [31:0] opa_hw_frac,
   input wire logic [18:0] eff_addr,
   input wire logic align_fault,
   input wire logic [15:0] instr_hw,
   input wire logic instr_long,
   input wire logic bank_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic plain_ff;
   logic [15:0] disp_ff;
   // Remember a bare displacement request, so its address can be judged a cycle later.
   always_ff @(posedge core_clk) begin
      plain_ff <= rd_req.base == 2'h3 && rd_req.no_base && rd_req.index == 3'h0;
      disp_ff <= rd_req.disp;
   end
   // Reset itself is the cause here, so this one must not be switched off by it.
   a_reset_state: assert property (
      disable iff (1'b0) !rst_n |=> !bank_sel && avs_waitrequest) else $error("reset state");
   a_bank_take: assert property (
      instruction_end_signal |=> bank_sel == $past(psw_bank_nxt)) else $error("bank not taken");
   a_bank_hold: assert property (
      !instruction_end_signal |=> $stable(bank_sel)) else $error("bank moved");
   a_long_fmt: assert property (
      1'b1 |=> instr_long == $past(instr_hw[11])) else $error("length wrong");
   a_align_flag: assert property (
      $past(rst_n) |-> align_fault == ($past(rd_req.fw) && eff_addr[0])) else $error("align");
   a_half_frac: assert property (
      $past(rst_n) && !$past(rd_req.dbl) |-> opa_hw_frac == {opa_data[63:48], 16'h0000}
      && opa_data[31:0] == 32'h0) else $error("half fraction");
   a_bare_disp: assert property (
      $past(rst_n) && plain_ff |-> eff_addr[15:0] == disp_ff) else $error("bare address");
   a_bus_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |-> ##[1:8] !avs_waitrequest) else $error("hang");
   a_ack_once: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
   a_unmapped_rd: assert property (
      avs_read && !avs_waitrequest && avs_address > 6'h29 |-> avs_readdata == 32'h0)
      else $error("unmapped data");
endmodule
`default_nettype wire

// [dv/bgr_regfile_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bgr_cfg.svh"
// *****
// Self-checking bench with a mirror of all banks.
// *****
module bgr_regfile_tb import bgr_pkg::*; ;
   typedef struct packed {logic [63:0] a; logic [31:0] b; logic [18:0] e;
      logic f; logic l;} bgr_exp_t;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, opb_data, opa_hw_frac;
   logic avs_waitrequest, instruction_end_signal, psw_bank_nxt, instr_long, align_fault, bank_sel;
   logic [3:0] psw_dsr_nxt;
   logic [63:0] opa_data;
   logic [18:0] eff_addr;
   logic [15:0] instr_hw = 16'h0;
   bgr_rd_req_t rd_req = '0;
   bgr_rd_req_t r;
   bgr_wr_req_t wr_req;
   logic [31:0] gm [2][8];
   logic [31:0] fm [8];
   logic [3:0] dm [2][8];
   logic bk = 1'b0, ctl = 1'b1, pv = 1'b0, pv1 = 1'b0;
   logic [3:0] ds = 4'h0;
   logic [15:0] h;
   int err_total = 0, compares = 0, seed = 97, cyc = 0, ends = 0;
   bgr_exp_t eq[$];
   bgr_exp_t x;
   logic [31:0] aq[$];
   always #5 core_clk = ~core_clk;
   bgr_regfile uut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .instruction_end_signal, .psw_bank_nxt, .psw_dsr_nxt,
      .rd_req, .opa_data, .opb_data, .opa_hw_frac, .eff_addr, .align_fault, .instr_hw,
      .instr_long, .wr_req, .bank_sel);
   bgr_dp_model dp (.core_clk, .wr_req, .instruction_end_signal, .psw_bank_nxt, .psw_dsr_nxt);
   task automatic chk(input string n, input logic [63:0] s, e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] rg(input logic f, input logic [2:0] n);
      return f ? fm[n] : gm[bk][n];
   endfunction
   // Expected outputs from the mirror; both halves of a word match, so either half may add.
   function automatic bgr_exp_t ex(input bgr_rd_req_t q);
      bgr_exp_t v;
      logic bu;
      logic [19:0] t;
      bu = !(q.base == 2'h3 && q.no_base);
      t[15:0] = q.disp + (bu ? gm[bk][q.base][15:0] : 16'h0)
         + (q.index != 3'h0 ? gm[bk][q.index][15:0] : 16'h0);
      t[19:16] = (ctl && bu) ? dm[bk][q.base] : ds;
      // A fullword operand at an odd halfword address must be flagged.
      v.f = q.fw && t[0];
      v.b = rg(q.fp, q.opb);
      v.e = t[18:0];
      v.a = q.dbl ? {rg(q.fp, q.opa & 3'h6), rg(q.fp, q.opa | 3'h1)} : {rg(q.fp, q.opa), 32'h0};
      return v;
   endfunction
   task automatic rd(input bgr_rd_req_t q);
      bgr_exp_t v;
      logic [15:0] ih;
      ih = 16'($random(seed));
      @(posedge core_clk);
      rd_req <= q;
      instr_hw <= ih;
      pv <= 1'b1;
      v = ex(q);
      v.l = ih[`BGR_ILEN_BIT];
      eq.push_back(v);
   endtask
   task automatic idle;
      @(posedge core_clk);
      pv <= 1'b0;
   endtask
   // End pulse through the partner, then the mirror follows with the old bank.
   task automatic wb(input logic w, f, d, s, input logic [2:0] n, input logic [63:0] v,
      input logic b, input logic [3:0] q);
      dp.commit(1'b1, w, f, d, s, n, v, b, q);
      if (w && s) dm[bk][n] = v[3:0];
      else if (w && f) fm[n] = v[31:0];
      else if (w && !d) gm[bk][n] = v[31:0];
      else if (w) begin
         gm[bk][n & 3'h6] = v[63:32];
         gm[bk][n | 3'h1] = v[31:0];
      end
      bk = b;
      ds = q;
      ends++;
   endtask
   // Bus master: hold everything until waitrequest is seen low, then release.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Monitor: pops the oldest note when a result is due.
   always @(posedge core_clk) begin
      pv1 <= pv;
      if (pv1) begin
         x = eq.pop_front();
         chk("opa", opa_data, x.a);
         chk("addr", 64'(eff_addr), 64'(x.e));
         chk("opb", 64'(opb_data), 64'(x.b));
         chk("hw", 64'(opa_hw_frac), 64'({x.a[63:48], 16'h0000}));
         chk("fault", 64'(align_fault), 64'(x.f));
         chk("long", 64'(instr_long), 64'(x.l));
      end
      if (avs_read && avs_waitrequest === 1'b0) begin
         chk("bus", 64'(avs_readdata), 64'(aq.pop_front()));
      end
   end
   // A hang counts as a mismatch; the full run needs well under a thousand cycles.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      aq.push_back(`BGR_CTRL_RST);
      bus(1'b0, `BGR_OFS_CTRL, 32'h0);
      chk("bank", 64'(bank_sel), 64'h0);
      for (int n = 0; n < 8; n++) begin
         h = 16'($random(seed));
         wb(1'b1, 1'b0, 1'b0, 1'b0, 3'(n), {4{h}}, 1'b0, 4'h0);
         wb(1'b1, 1'b1, 1'b0, 1'b0, 3'(n), {4{~h}}, 1'b0, 4'h0);
         wb(1'b1, 1'b0, 1'b0, 1'b1, 3'(n), {16{h[7:4]}}, 1'b0, 4'h0);
         gm[1][n] = {2{h[7:0], h[15:8]}};
         bus(1'b1, 6'h08 + 6'(n), gm[1][n]);
         dm[1][n] = h[3:0];
         bus(1'b1, `BGR_OFS_DSE + 6'h08 + 6'(n), 32'(h[3:0]));
      end
      $display("fill done");
      for (int p = 0; p < 4; p++) begin
         wb(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 64'h0, p[0], 4'($random(seed)));
         ctl = p[1];
         bus(1'b1, `BGR_OFS_CTRL, 32'(p[1]));
         h = 16'($random(seed));
         wb(1'b1, 1'b0, 1'b1, 1'b0, 3'(2 * p + 1), {{2{h}}, {8{~h[3:0]}}}, p[0], ds);
         repeat (24) begin
            r = 31'($random(seed));
            r.fp = 1'b0;
            rd(r);
         end
         idle();
         $display("phase %0d done", p);
      end
      // A write without an end pulse must be dropped.
      dp.commit(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 64'h0, bk, ds);
      for (int n = 0; n < 8; n++) begin
         r = 31'($random(seed));
         r.opa = 3'(n);
         r.opb = 3'h2;
         r.fp = n[0];
         r.dbl = 1'b0;
         r.base = 2'h3;
         r.no_base = 1'b1;
         r.index = 3'(n & 3);
         rd(r);
      end
      idle();
      $display("refused write done");
      // All 40 storage words in address order: fixed, floating, then sector extensions.
      for (int i = 0; i < 40; i++) begin
         aq.push_back(i < 16 ? gm[i / 8][i % 8] : i < 24 ? fm[i % 8]
            : 32'(dm[(i - 24) / 8][i % 8]));
         bus(1'b0, 6'(i), 32'h0);
      end
      // Status word: one count per end pulse, then the latched sector and bank.
      aq.push_back({16'(ends), 11'h000, ds, bk});
      bus(1'b0, `BGR_OFS_STAT, 32'h0);
      bus(1'b1, 6'h3F, 32'hFFFF_FFFF);
      aq.push_back(32'h0);
      bus(1'b0, 6'h3F, 32'h0);
      $display("bus read done");
      final_report();
   end
endmodule
bind bgr_regfile bgr_regfile_asserts chk_u (.core_clk, .rst_n, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .instruction_end_signal, .psw_bank_nxt,
   .rd_req, .opa_data, .opa_hw_frac, .eff_addr, .align_fault, .instr_hw, .instr_long, .bank_sel);
`default_nettype wire

// [src/bgr_cfg.svh]
`ifndef BGR_CFG_SVH
`define BGR_CFG_SVH
// Avalon word offsets of the register window.
`define BGR_OFS_GPR 6'h00
`define BGR_OFS_FPR 6'h10
`define BGR_OFS_DSE 6'h18
`define BGR_OFS_CTRL 6'h28
`define BGR_OFS_STAT 6'h29
// Control register fields and reset value.
`define BGR_CTRL_EXT_BIT 0
`define BGR_CTRL_RST 32'h0000_0001
// Instruction length field position in a halfword (bit 4 counted from the left).
`define BGR_ILEN_BIT 11
// Reset value of the active bank.
`define BGR_BANK_RST 1'b0
// Machine cycle time and core clock period.
`define BGR_MCYC_NS 250
`define BGR_CLK_NS 10
`define BGR_MCYC_CYC (`BGR_MCYC_NS / `BGR_CLK_NS)
`endif

// [src/bgr_pkg.sv]
package bgr_pkg;
   // Read side request from the address generation stage.
   typedef struct packed {
      logic [2:0] opa;
      logic [2:0] opb;
      logic [1:0] base;
      logic no_base;
      logic [2:0] index;
      logic dbl;
      logic fp;
      logic fw;
      logic [15:0] disp;
   } bgr_rd_req_t;
   // Write-back request from the execution stage.
   typedef struct packed {
      logic en;
      logic fp;
      logic dbl;
      logic data_sector_extension;
      logic [2:0] regn;
      logic [63:0] data;
   } bgr_wr_req_t;
   // Bus slave handshake states.
   typedef enum logic [0:0] {
      BGR_BUS_IDLE = 1'b0,
      BGR_BUS_ACK = 1'b1
   } bgr_bus_st_t;
endpackage

// [src/bgr_regfile.sv]
`include "bgr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bgr_regfile
   import bgr_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Avalon-MM register slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Status word fields from the sequencer.
   input wire logic instruction_end_signal,
   input wire logic psw_bank_nxt,
   input wire logic [3:0] psw_dsr_nxt,
   // Operand read request and results.
   input wire bgr_rd_req_t rd_req,
   output logic [63:0] opa_data,
   output logic [31:0] opb_data,
   output logic [31:0] opa_hw_frac,
   output logic [18:0] eff_addr,
   output logic align_fault,
   // Instruction length decode.
   input wire logic [15:0] instr_hw,
   output logic instr_long,
   // Write-back request.
   input wire bgr_wr_req_t wr_req,
   // Current status.
   output logic bank_sel
);

   // ************************************************************
   // Storage and state
   // ************************************************************

   // Word 0 is bank 0 register 0; the bank is the upper index bit.
   logic [31:0] gpr_ff [0:15];
   logic [31:0] fpr_ff [0:7];
   logic [3:0] dse_ff [0:15];
   logic bank_ff;
   logic [3:0] dsr_ff;
   logic [31:0] ctrl_ff;
   logic [15:0] icount_ff;
   bgr_bus_st_t bus_st_ff;
   logic [31:0] rdata_ff;
   logic [63:0] opa_ff;
   logic [31:0] opb_ff;
   logic [31:0] hw_ff;
   logic [18:0] ea_ff;
   logic fault_ff;
   logic long_ff;
   logic wait_ff;

   // ************************************************************
   // Helpers
   // ************************************************************

   // Flat index of register n in the given bank.
   function automatic logic [3:0] gidx(input logic bank, input logic [2:0] n);
      gidx = {bank, n};
   endfunction

   // Fixed or floating register n of the active bank, one word.
   function automatic logic [31:0] rdw(input logic fp, input logic [2:0] n);
      if (fp) begin
         rdw = fpr_ff[n];
      end else begin
         rdw = gpr_ff[gidx(bank_ff, n)];
      end
   endfunction

   // Bus window decode, shared so the write and read maps cannot drift apart.
   function automatic logic hit_gpr(input logic [5:0] a);
      hit_gpr = (a < `BGR_OFS_FPR);
   endfunction

   // Floating window sits between the fixed registers and the extensions.
   function automatic logic hit_fpr(input logic [5:0] a);
      hit_fpr = (a >= `BGR_OFS_FPR) && (a < `BGR_OFS_DSE);
   endfunction

   // Sector extension window, one slot per fixed register of both banks.
   function automatic logic hit_dse(input logic [5:0] a);
      hit_dse = (a >= `BGR_OFS_DSE) && (a < `BGR_OFS_CTRL);
   endfunction

   // Slot number of an extension; only meaningful inside its window.
   function automatic logic [3:0] dse_slot(input logic [5:0] a);
      dse_slot = 4'(a - `BGR_OFS_DSE);
   endfunction

   // ************************************************************
   // Combinational decode
   // ************************************************************

   logic [2:0] pair_even;
   logic [63:0] nxt_opa;
   logic base_used;
   logic idx_used;
   logic [15:0] base_val;
   logic [15:0] idx_val;
   logic [15:0] sum16;
   logic [3:0] ext;
   logic [19:0] addr20;
   logic end_wr;
   logic bus_go;

   // Doubleword pairs start at the even register; odd operand bit is ignored.
   assign pair_even = {rd_req.opa[2:1], 1'b0};

   always_comb begin
      if (rd_req.dbl) begin
         // Upper half from the even register, lower from the odd one.
         nxt_opa = {rdw(rd_req.fp, pair_even),
                    rdw(rd_req.fp, pair_even | 3'h1)};
      end else begin
         nxt_opa = {rdw(rd_req.fp, rd_req.opa), 32'h0000_0000};
      end
   end

   // Code 11 only counts as register 3 when the decoder says a base exists.
   assign base_used = !(rd_req.base == 2'h3 && rd_req.no_base);
   assign idx_used = (rd_req.index != 3'h0);
   assign base_val = base_used ? gpr_ff[gidx(bank_ff, {1'b0, rd_req.base})][15:0] : 16'h0000;
   assign idx_val = idx_used ? gpr_ff[gidx(bank_ff, rd_req.index)][15:0] : 16'h0000;
   assign sum16 = rd_req.disp + base_val + idx_val;

   // The sector comes from the base register's extension or the status word.
   assign ext = (ctrl_ff[`BGR_CTRL_EXT_BIT] && base_used) ?
                dse_ff[gidx(bank_ff, {1'b0, rd_req.base})] : dsr_ff;
   // The top extension bit falls outside the 19-bit halfword space.
   assign addr20 = {ext, sum16};

   // Writes only commit on the instruction end so the pipe sees stable operands.
   assign end_wr = wr_req.en && instruction_end_signal;

   // A bus write yields to a datapath commit in the same cycle.
   assign bus_go = (bus_st_ff == BGR_BUS_IDLE) && (avs_read || avs_write) && !end_wr;

   // ************************************************************
   // Status word
   // ************************************************************

   // Bank and sector field follow the status word at every instruction end.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bank_ff <= `BGR_BANK_RST;
         dsr_ff <= 4'h0;
      end else if (instruction_end_signal) begin
         bank_ff <= psw_bank_nxt;
         dsr_ff <= psw_dsr_nxt;
      end
   end

   // Completed instruction count, visible in the status register.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         icount_ff <= 16'h0000;
      end else if (instruction_end_signal) begin
         icount_ff <= icount_ff + 16'h0001;
      end
   end

   // ************************************************************
   // Register storage writes
   // ************************************************************

   // Fixed-point registers; only the active bank takes datapath writes.
   always_ff @(posedge core_clk) begin
      if (end_wr && !wr_req.fp && !wr_req.data_sector_extension) begin
         if (wr_req.dbl) begin
            gpr_ff[gidx(bank_ff, {wr_req.regn[2:1], 1'b0})] <= wr_req.data[63:32];
            gpr_ff[gidx(bank_ff, {wr_req.regn[2:1], 1'b1})] <= wr_req.data[31:0];
         end else begin
            gpr_ff[gidx(bank_ff, wr_req.regn)] <= wr_req.data[31:0];
         end
      end else if (bus_go && avs_write && hit_gpr(avs_address)) begin
         gpr_ff[avs_address[3:0]] <= avs_writedata;
      end
   end

   // Floating-point registers, one bank only.
   always_ff @(posedge core_clk) begin
      if (end_wr && wr_req.fp && !wr_req.data_sector_extension) begin
         if (wr_req.dbl) begin
            fpr_ff[{wr_req.regn[2:1], 1'b0}] <= wr_req.data[63:32];
            fpr_ff[{wr_req.regn[2:1], 1'b1}] <= wr_req.data[31:0];
         end else begin
            fpr_ff[wr_req.regn] <= wr_req.data[31:0];
         end
      end else if (bus_go && avs_write && hit_fpr(avs_address)) begin
         fpr_ff[avs_address[2:0]] <= avs_writedata;
      end
   end

   // Sector extensions, one per fixed register of each bank.
   always_ff @(posedge core_clk) begin
      if (end_wr && wr_req.data_sector_extension) begin
         dse_ff[gidx(bank_ff, wr_req.regn)] <= wr_req.data[3:0];
      end else if (bus_go && avs_write && hit_dse(avs_address)) begin
         dse_ff[dse_slot(avs_address)] <= avs_writedata[3:0];
      end
   end

   // ************************************************************
   // Registered operand outputs
   // ************************************************************

   // Operands are captured one cycle after the request.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         opa_ff <= 64'h0000_0000_0000_0000;
         opb_ff <= 32'h0000_0000;
      end else begin
         opa_ff <= nxt_opa;
         opb_ff <= rdw(rd_req.fp, rd_req.opb);
      end
   end

   // Halfword operand is the leftmost halfword as a left-aligned fraction.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hw_ff <= 32'h0000_0000;
      end else begin
         hw_ff <= {nxt_opa[63:48], 16'h0000};
      end
   end

   // Effective halfword address and fullword alignment check.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ea_ff <= 19'h00000;
         fault_ff <= 1'b0;
      end else begin
         ea_ff <= addr20[18:0];
         fault_ff <= rd_req.fw && addr20[0];
      end
   end

   // Long format is flagged by one bit of the first halfword.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         long_ff <= 1'b0;
      end else begin
         long_ff <= instr_hw[`BGR_ILEN_BIT];
      end
   end

   // ************************************************************
   // Avalon slave
   // ************************************************************

   // Each access waits one cycle, or longer while a datapath commit holds off bus_go, then completes with waitrequest low.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_st_ff <= BGR_BUS_IDLE;
      end else begin
         case (bus_st_ff)
            BGR_BUS_IDLE: begin
               if (bus_go) begin
                  bus_st_ff <= BGR_BUS_ACK;
               end
            end
            BGR_BUS_ACK: begin
               bus_st_ff <= BGR_BUS_IDLE;
            end
            default: begin
               bus_st_ff <= BGR_BUS_IDLE;
            end
         endcase
      end
   end

   // Waitrequest has its own flop so the pin never carries decode logic.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !bus_go;
      end
   end

   // Control register steers the sector extension source.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_ff <= `BGR_CTRL_RST;
      end else if (bus_go && avs_write && avs_address == `BGR_OFS_CTRL) begin
         ctrl_ff <= {31'h0000_0000, avs_writedata[`BGR_CTRL_EXT_BIT]};
      end
   end

   // Read data is latched on acceptance and held through the ack cycle.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (bus_go) begin
         if (!avs_read) begin
            rdata_ff <= 32'h0000_0000;
         end else if (hit_gpr(avs_address)) begin
            rdata_ff <= gpr_ff[avs_address[3:0]];
         end else if (hit_fpr(avs_address)) begin
            rdata_ff <= fpr_ff[avs_address[2:0]];
         end else if (hit_dse(avs_address)) begin
            rdata_ff <= {28'h0000000, dse_ff[dse_slot(avs_address)]};
         end else if (avs_address == `BGR_OFS_CTRL) begin
            rdata_ff <= ctrl_ff;
         end else if (avs_address == `BGR_OFS_STAT) begin
            rdata_ff <= {icount_ff, 11'h000, dsr_ff, bank_ff};
         end else begin
            rdata_ff <= 32'h0000_0000; // Unmapped reads return zero.
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign opa_data = opa_ff;
   assign opb_data = opb_ff;
   assign opa_hw_frac = hw_ff;
   assign eff_addr = ea_ff;
   assign align_fault = fault_ff;
   assign instr_long = long_ff;
   assign bank_sel = bank_ff;

endmodule
`default_nettype wire
